/* rtl/switch_detect_ctrl.sv */
// serial link, interrupt, wake and mode control of the switch detection interface
//
// What this block does
// - normal mode: enabled switch change pulls interrupt
// - chip select fall captures interrupt into flag
// - flag shows only this device's own interrupt
// - chip select rise releases interrupt unless changed
// - sleep: interrupt line fall wakes, wake high
// - wake line low in normal, released sleeping
// - sleep: wake fall wakes, gated by interrupt
// - programmable inputs: polarity sets closed meaning
// - ground inputs: low means closed
// - response always carries switches, interrupt, thermal
// - chip select fall loads switch states
// - transfer is twenty-four clocks, or forty-eight chained, master supplies
// - supply loss keeps mode, sleep persists
// - no supply: ignore serial, chip select, interrupt
// - reset and reset command load defaults
// - listed events all enter normal mode
// - commands apply only normal with supply
// - twelve command kinds are decoded
// - polarity command: low byte sets battery/ground
// - closed reads one whatever polarity; rewritable
// - command takes effect at chip select rise
// - sample on clock fall, drive on rise, MSB first
`timescale 1ns/1ns
`default_nettype none
module switch_detect_ctrl
  import switch_detect_pkg::*;
#(
  parameter int MAX_CHAIN = 2
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // serial link pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_n_out,
  // open-drain interrupt line
  input wire logic int_n_in,
  output logic int_out,
  output logic int_oe_n_out,
  // open-drain wake line
  input wire logic wake_n_in,
  output logic wake_out,
  output logic wake_oe_n_out,
  // supply and status levels
  input wire logic logic_supply_in,
  input wire logic thermal_flag_in,
  input wire logic int_timer_expired_in,
  input wire logic enter_sleep_in,
  // comparator results, high means above the threshold
  input wire logic [PROG_COUNT-1:0] programmable_inputs_in,
  input wire logic [GROUND_COUNT-1:0] ground_only_inputs_in,
  // settings and mode toward the analog section
  output config_type cfg_out,
  output mode_type mode_out,
  output logic calib_pulse_out
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (MAX_CHAIN < 1 || MAX_CHAIN > 2) begin : g_bad_chain
    $error("MAX_CHAIN must be 1 or 2");
  end

  localparam int SYNC_BITS = 8 + SWITCH_COUNT;
  localparam logic [SYNC_BITS-1:0] SYNC_INIT = {1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
                                                {SWITCH_COUNT{1'b0}}};
  localparam logic [CNT_BITS-1:0] ONE_XFER = CNT_BITS'(XFER_BITS);
  localparam logic [CNT_BITS-1:0] TWO_XFER = CNT_BITS'(2 * XFER_BITS);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_sync_n;
  logic [SYNC_BITS-1:0] sync_vec;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic int_n_s;
  logic wake_n_s;
  logic supply_s;
  logic thermal_s;
  logic timer_s;
  logic [PROG_COUNT-1:0] prog_s;
  logic [GROUND_COUNT-1:0] gnd_s;

  // asynchronous assertion, release after two edges
  bit_sync #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_rst_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(1'b1),
    .sync_out(rst_sync_n)
  );

  // every pin but enter_sleep_in and every comparator level passes two flops
  bit_sync #(
    .WIDTH(SYNC_BITS),
    .INIT(SYNC_INIT)
  ) u_pin_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_sync_n),
    .async_in({cs_n_in, sclk_in, si_in, int_n_in, wake_n_in, logic_supply_in, thermal_flag_in,
               int_timer_expired_in, ground_only_inputs_in, programmable_inputs_in}),
    .sync_out(sync_vec)
  );

  // unpack the synchronised levels
  assign {cs_n_s, sclk_s, si_s, int_n_s, wake_n_s, supply_s, thermal_s, timer_s, gnd_s, prog_s} = sync_vec;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // returns the settings after one received command word
  function automatic config_type apply_cmd(input config_type c, input logic [XFER_BITS-1:0] w);
    config_type r;
    logic [OPCODE_BITS-1:0] op;
    r = c;
    op = w[OPCODE_LSB +: OPCODE_BITS];
    case (op)
      OP_POLARITY: begin
        r.polarity = w[PROG_COUNT-1:0];
      end
      OP_WAKE_PROG: begin
        r.wake_en[PROG_COUNT-1:0] = w[PROG_COUNT-1:0];
      end
      OP_WAKE_GND: begin
        r.wake_en[SWITCH_COUNT-1:PROG_COUNT] = w[GROUND_COUNT-1:0];
      end
      OP_WET_PROG: begin
        r.wet_high[PROG_COUNT-1:0] = w[PROG_COUNT-1:0];
      end
      OP_WET_GND: begin
        r.wet_high[SWITCH_COUNT-1:PROG_COUNT] = w[GROUND_COUNT-1:0];
      end
      OP_TIMER_PROG: begin
        r.timer_en[PROG_COUNT-1:0] = w[PROG_COUNT-1:0];
      end
      OP_TIMER_GND: begin
        r.timer_en[SWITCH_COUNT-1:PROG_COUNT] = w[GROUND_COUNT-1:0];
      end
      OP_TRI_PROG: begin
        r.tristate[PROG_COUNT-1:0] = w[PROG_COUNT-1:0];
      end
      OP_TRI_GND: begin
        r.tristate[SWITCH_COUNT-1:PROG_COUNT] = w[GROUND_COUNT-1:0];
      end
      OP_ANALOG: begin
        r.analog_sel = w[ANALOG_SEL_LSB +: ANALOG_SEL_BITS];
        r.analog_cur = w[ANALOG_CUR_LSB +: ANALOG_CUR_BITS];
      end
      OP_RESET: begin
        r = CONFIG_RESET;
      end
      default: begin
        r = c;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // switch interpretation
  // ----------------------------------------------------------------
  state_type st_q;
  state_type st_d;
  logic [SWITCH_COUNT-1:0] closed;

  // closed switches read as one for both input types
  always_comb begin
    closed[PROG_COUNT-1:0] = ~(prog_s ^ st_q.cfg.polarity);
    closed[SWITCH_COUNT-1:PROG_COUNT] = ~gnd_s;
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  logic [SWITCH_COUNT-1:0] change;
  logic any_change;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic wake_fall;
  logic int_fall;
  logic timer_rise;
  logic count_ok;

  // edge detection on the synchronised pins
  always_comb begin
    cs_fall = st_q.cs_n_prev & ~cs_n_s & supply_s;
    cs_rise = ~st_q.cs_n_prev & cs_n_s & st_q.in_xfer;
    sclk_rise = ~st_q.sclk_prev & sclk_s & st_q.in_xfer & ~cs_n_s;
    sclk_fall = st_q.sclk_prev & ~sclk_s & st_q.in_xfer & ~cs_n_s;
    wake_fall = st_q.wake_n_prev & ~wake_n_s;
    int_fall = st_q.int_n_prev & ~int_n_s;
    timer_rise = ~st_q.timer_prev & timer_s;
    change = (st_q.settle == SETTLE_DONE) ? ((closed ^ st_q.prev_closed) & st_q.cfg.wake_en) : '0;
    any_change = |change;
    count_ok = (st_q.bit_cnt == ONE_XFER) || ((MAX_CHAIN > 1) && (st_q.bit_cnt == TWO_XFER));
  end

  // next state of the whole block
  always_comb begin
    st_d = st_q;
    st_d.calib_pulse = 1'b0;
    st_d.cs_n_prev = cs_n_s;
    st_d.sclk_prev = sclk_s;
    st_d.int_n_prev = int_n_s;
    st_d.wake_n_prev = wake_n_s;
    st_d.timer_prev = timer_s;
    st_d.prev_closed = closed;
    if (st_q.settle != SETTLE_DONE) begin
      st_d.settle = st_q.settle + 2'h1;
    end

    // start of a transfer: load switches, flags and own interrupt
    if (cs_fall) begin
      st_d.in_xfer = 1'b1;
      st_d.cmd_ok = (st_q.mode == MODE_NORMAL);
      st_d.shreg = {XFER_BITS{1'b0}};
      st_d.shreg[SWITCH_COUNT-1:0] = closed;
      st_d.shreg[RSP_INT_BIT] = st_q.int_drive;
      st_d.shreg[RSP_THERMAL_BIT] = thermal_s;
      st_d.bit_cnt = '0;
      st_d.change_in_cs = 1'b0;
      st_d.so = 1'b0;
      st_d.so_oe_n = 1'b0;
    end

    // drive on the clock rise, sample on the clock fall
    if (sclk_rise) begin
      st_d.so = st_q.shreg[XFER_BITS-1];
    end
    if (sclk_fall) begin
      st_d.shreg = {st_q.shreg[XFER_BITS-2:0], si_s};
      if (st_q.bit_cnt != CNT_MAX) begin
        st_d.bit_cnt = st_q.bit_cnt + 6'h01;
      end
    end

    // end of a transfer: act on the command and release the interrupt
    if (cs_rise) begin
      st_d.in_xfer = 1'b0;
      st_d.so = 1'b0;
      st_d.so_oe_n = 1'b1;
      if (st_q.cmd_ok && (st_q.mode == MODE_NORMAL) && supply_s && count_ok) begin
        st_d.cfg = apply_cmd(st_q.cfg, st_q.shreg);
        if (st_q.shreg[OPCODE_LSB +: OPCODE_BITS] == OP_CALIBRATE) begin
          st_d.calib_pulse = 1'b1;
        end
      end
      if (!st_q.change_in_cs) begin
        st_d.int_drive = 1'b0;
      end
    end

    // losing the supply ends any transfer; mode is left alone
    if (st_q.in_xfer && !supply_s && !cs_rise) begin
      st_d.in_xfer = 1'b0;
      st_d.so = 1'b0;
      st_d.so_oe_n = 1'b1;
    end

    // wake-up sources while asleep
    if (st_q.mode == MODE_SLEEP) begin
      if (wake_fall && (!supply_s || int_n_s)) begin
        st_d.mode = MODE_NORMAL;
      end
      if (int_fall && supply_s && wake_n_s) begin
        st_d.mode = MODE_NORMAL;
      end
      if (cs_fall || timer_rise || any_change) begin
        st_d.mode = MODE_NORMAL;
      end
    end else if (enter_sleep_in && !st_q.in_xfer && !cs_fall) begin
      st_d.mode = MODE_SLEEP;
      st_d.int_drive = 1'b0;
    end

    // a change always sets, winning over a release in the same cycle
    if (any_change) begin
      st_d.int_drive = 1'b1;
      if (st_q.in_xfer && !cs_rise) begin
        st_d.change_in_cs = 1'b1;
      end
    end

    // open-drain enables follow the new state
    st_d.int_oe_n = ~st_d.int_drive;
    st_d.wake_oe_n = (st_d.mode == MODE_SLEEP);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power-on state: normal mode with default settings
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q <= '0;
      st_q.mode <= MODE_NORMAL;
      st_q.cfg <= CONFIG_RESET;
      st_q.cs_n_prev <= 1'b1;
      st_q.int_n_prev <= 1'b1;
      st_q.wake_n_prev <= 1'b1;
      st_q.so_oe_n <= 1'b1;
      st_q.int_oe_n <= 1'b1;
      st_q.wake_oe_n <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a state flop
  assign so_out = st_q.so;
  assign so_oe_n_out = st_q.so_oe_n;
  assign int_out = st_q.pin_low;
  assign int_oe_n_out = st_q.int_oe_n;
  assign wake_out = st_q.pin_low;
  assign wake_oe_n_out = st_q.wake_oe_n;
  assign cfg_out = st_q.cfg;
  assign mode_out = st_q.mode;
  assign calib_pulse_out = st_q.calib_pulse;

endmodule
`default_nettype wire

/* rtl/switch_detect_pkg.sv */
// constants, field layouts and types shared by the switch detection control logic
package switch_detect_pkg;

  // ----------------------------------------------------------------
  // input counts and serial word geometry
  // ----------------------------------------------------------------
  localparam int PROG_COUNT = 8;
  localparam int GROUND_COUNT = 14;
  localparam int SWITCH_COUNT = PROG_COUNT + GROUND_COUNT;
  localparam int XFER_BITS = 24;
  localparam int CNT_BITS = 6;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 6'h3f;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int OPCODE_LSB = 16;
  localparam int OPCODE_BITS = 8;
  localparam int ANALOG_SEL_LSB = 0;
  localparam int ANALOG_SEL_BITS = 5;
  localparam int ANALOG_CUR_LSB = 5;
  localparam int ANALOG_CUR_BITS = 2;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_POLARITY = 8'h01;
  localparam logic [7:0] OP_WAKE_PROG = 8'h02;
  localparam logic [7:0] OP_WAKE_GND = 8'h03;
  localparam logic [7:0] OP_WET_PROG = 8'h04;
  localparam logic [7:0] OP_WET_GND = 8'h05;
  localparam logic [7:0] OP_TIMER_PROG = 8'h07;
  localparam logic [7:0] OP_TIMER_GND = 8'h08;
  localparam logic [7:0] OP_TRI_PROG = 8'h09;
  localparam logic [7:0] OP_TRI_GND = 8'h0a;
  localparam logic [7:0] OP_ANALOG = 8'h0b;
  localparam logic [7:0] OP_CALIBRATE = 8'h0c;
  localparam logic [7:0] OP_RESET = 8'h7f;

  // ----------------------------------------------------------------
  // response word fields
  // ----------------------------------------------------------------
  localparam int RSP_THERMAL_BIT = 23;
  localparam int RSP_INT_BIT = 22;

  // ----------------------------------------------------------------
  // settle time of the comparator synchronisers after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] SETTLE_DONE = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {MODE_NORMAL, MODE_SLEEP} mode_type;

  typedef struct packed {
    logic [PROG_COUNT-1:0] polarity;
    logic [SWITCH_COUNT-1:0] wake_en;
    logic [SWITCH_COUNT-1:0] wet_high;
    logic [SWITCH_COUNT-1:0] timer_en;
    logic [SWITCH_COUNT-1:0] tristate;
    logic [ANALOG_SEL_BITS-1:0] analog_sel;
    logic [ANALOG_CUR_BITS-1:0] analog_cur;
  } config_type;

  localparam config_type CONFIG_RESET = '{
    polarity: 8'hff,
    wake_en: 22'h3fffff,
    wet_high: 22'h3fffff,
    timer_en: 22'h3fffff,
    tristate: 22'h3fffff,
    analog_sel: 5'h00,
    analog_cur: 2'h0
  };

  typedef struct packed {
    mode_type mode;
    config_type cfg;
    logic [XFER_BITS-1:0] shreg;
    logic [CNT_BITS-1:0] bit_cnt;
    logic in_xfer;
    logic cmd_ok;
    logic int_drive;
    logic change_in_cs;
    logic [SWITCH_COUNT-1:0] prev_closed;
    logic [1:0] settle;
    logic cs_n_prev;
    logic sclk_prev;
    logic int_n_prev;
    logic wake_n_prev;
    logic timer_prev;
    logic so;
    logic so_oe_n;
    logic int_oe_n;
    logic wake_oe_n;
    logic calib_pulse;
    logic pin_low;
  } state_type;

endpackage

/* rtl/bit_sync.sv */
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_state_type;

  sync_state_type st_q;
  sync_state_type st_d;

  // ----------------------------------------------------------------
  // width check
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("bit_sync needs at least one bit");
  end

  // first stage feeds only the second stage
  always_comb begin
    st_d.meta = async_in;
    st_d.held = st_q.meta;
  end

  // both stages
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= {INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.held;

endmodule
`default_nettype wire

/* verification/switch_detect_ctrl_sva.sv */
// pin-level assertions for the switch detection control logic
`timescale 1ns/1ns
`default_nettype none
module switch_detect_ctrl_sva
  import switch_detect_pkg::*;
#(
  parameter int MAX_CHAIN = 2
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // serial link
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic si_in,
  input wire logic so_out,
  input wire logic so_oe_n_out,
  // interrupt and wake lines
  input wire logic int_n_in,
  input wire logic int_out,
  input wire logic int_oe_n_out,
  input wire logic wake_n_in,
  input wire logic wake_out,
  input wire logic wake_oe_n_out,
  // supply and status
  input wire logic logic_supply_in,
  input wire logic thermal_flag_in,
  input wire logic int_timer_expired_in,
  input wire logic enter_sleep_in,
  // comparator results
  input wire logic [PROG_COUNT-1:0] programmable_inputs_in,
  input wire logic [GROUND_COUNT-1:0] ground_only_inputs_in,
  // settings and mode
  input wire config_type cfg_out,
  input wire mode_type mode_out,
  input wire logic calib_pulse_out
);
  wire logic [21:0] sw = {ground_only_inputs_in, programmable_inputs_in};
  logic [21:0] sw_q;
  logic moved_q;
  // remembers a switch movement while selected
  always_ff @(posedge sys_clk_in) begin
    sw_q <= sw;
    moved_q <= !cs_n_in && (moved_q || sw != sw_q);
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // select rises after a quiet transfer
  sequence clean_rise_s;
    $rose(cs_n_in) && !moved_q && $stable(sw) ##1 $stable(sw) [*2];
  endsequence
  so_hiz_a: assert property (so_oe_n_out |-> !so_out && !int_out)
    else $error("serial out not low while released");
  wake_mode_a: assert property (!wake_out && wake_oe_n_out == (mode_out == MODE_SLEEP))
    else $error("wake line does not follow mode");
  so_enable_a: assert property (mode_out == MODE_NORMAL && $fell(cs_n_in) && logic_supply_in &&
    $past(logic_supply_in, 4) |-> ##3 !so_oe_n_out) else $error("serial out not enabled");
  so_release_a: assert property ($rose(cs_n_in) |-> ##3 so_oe_n_out && !so_out)
    else $error("serial out not released");
  cfg_hold_a: assert property (!$stable(cfg_out) |-> $past(cs_n_in, 3) && !$past(cs_n_in, 4))
    else $error("settings changed outside select rise");
  int_clear_a: assert property (clean_rise_s |-> ##1 int_oe_n_out)
    else $error("interrupt not cleared");
  int_assert_a: assert property (mode_out == MODE_NORMAL && $changed(ground_only_inputs_in) &&
    cfg_out.wake_en[21:8] == 14'h3fff && $past(rst_n_in, 8) |-> ##3 !int_oe_n_out)
    else $error("interrupt not raised");
  sleep_wake_a: assert property (mode_out == MODE_SLEEP && $fell(wake_n_in) && int_n_in
    |-> ##3 mode_out == MODE_NORMAL) else $error("no wake on wake line");
  int_wake_a: assert property (mode_out == MODE_SLEEP && $fell(int_n_in) && wake_n_in &&
    logic_supply_in && $past(logic_supply_in, 4) |-> ##3 mode_out == MODE_NORMAL)
    else $error("no wake on interrupt line");
  no_supply_a: assert property (!logic_supply_in [*4] |-> so_oe_n_out)
    else $error("serial out driven without supply");
endmodule
bind switch_detect_ctrl switch_detect_ctrl_sva #(.MAX_CHAIN(MAX_CHAIN)) sva_i (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in), .si_in(si_in),
  .so_out(so_out), .so_oe_n_out(so_oe_n_out), .int_n_in(int_n_in), .int_out(int_out),
  .int_oe_n_out(int_oe_n_out), .wake_n_in(wake_n_in), .wake_out(wake_out), .wake_oe_n_out(wake_oe_n_out),
  .logic_supply_in(logic_supply_in), .thermal_flag_in(thermal_flag_in),
  .int_timer_expired_in(int_timer_expired_in), .enter_sleep_in(enter_sleep_in),
  .programmable_inputs_in(programmable_inputs_in), .ground_only_inputs_in(ground_only_inputs_in),
  .cfg_out(cfg_out), .mode_out(mode_out), .calib_pulse_out(calib_pulse_out));
`default_nettype wire

/* verification/spi_master_model.sv */
// serial master standing in for the microcontroller
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  // clock
  input wire logic clk_in,
  // serial link
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out,
  input wire logic so_in
);
  // idle: deselected with the clock low
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end
  // one transfer, eight system clocks per serial clock
  task automatic xfer(input int nbits, input logic [47:0] cmd, output logic [47:0] rsp);
    rsp = '0;
    cs_n_out <= 1'b0; // clock low at select edge
    repeat (4) @(posedge clk_in);
    for (int i = nbits - 1; i >= 0; i--) begin // msb first, 24 clocks, 48 when chained
      si_out <= cmd[i];
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in); // 320 ns period
      rsp[i] = so_in;
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    si_out <= ~si_out; // a released data line keeps no value
    repeat (4) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* verification/switch_detect_ctrl_tb.sv */
// self-checking bench for the switch detection control logic
`timescale 1ns/1ns
`default_nettype none
module switch_detect_ctrl_tb;
  import switch_detect_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_int_low = 1'b0;
  logic ext_wake_low = 1'b0;
  logic supply = 1'b1;
  logic thermal = 1'b1;
  logic sleep_req = 1'b0;
  logic timer = 1'b0;
  logic [7:0] prog = 8'h5a;
  logic [13:0] gnd = 14'h2a5c;
  logic [7:0] pol = 8'hff;
  logic so_last = 1'b0;
  logic cs_n, sclk, si, so, so_oe_n, int_oe_n, wake_oe_n, calib;
  logic [47:0] rsp;
  config_type cfg;
  mode_type mode;
  int fails = 0;
  int num_checks = 0;
  int calib_seen = 0;
  // open-drain wires with pull-ups, released serial out shows no stale value
  wire logic int_n = int_oe_n & ~ext_int_low;
  wire logic wake_n = wake_oe_n & ~ext_wake_low;
  wire logic so_line = so_oe_n ? ~so_last : so;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (!so_oe_n) so_last <= so;
    if (calib === 1'b1) calib_seen <= calib_seen + 1;
  end
  spi_master_model m (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so_line));
  switch_detect_ctrl #(.MAX_CHAIN(2)) uut (.sys_clk_in(clk), .rst_n_in(rst_n), .cs_n_in(cs_n),
    .sclk_in(sclk), .si_in(si), .so_out(so), .so_oe_n_out(so_oe_n), .int_n_in(int_n), .int_out(),
    .int_oe_n_out(int_oe_n), .wake_n_in(wake_n), .wake_out(), .wake_oe_n_out(wake_oe_n),
    .logic_supply_in(supply), .thermal_flag_in(thermal), .int_timer_expired_in(timer),
    .enter_sleep_in(sleep_req), .programmable_inputs_in(prog), .ground_only_inputs_in(gnd),
    .cfg_out(cfg), .mode_out(mode), .calib_pulse_out(calib));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic clocks(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [23:0] exp_rsp(input logic flag);
    return {thermal, flag, ~gnd, ~(pol ^ prog)};
  endfunction
  task automatic xfer(input logic [23:0] cmd, input logic [23:0] exp);
    m.xfer(24, 48'(cmd), rsp);
    chk("response", 128'(rsp[23:0]), 128'(exp));
  endtask
  task automatic nap();
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    clocks(2);
    chk("mode", 128'(mode), 128'(MODE_SLEEP));
    chk("wake", 128'(wake_oe_n), 128'h1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clocks(2);
    rst_n <= 1'b1;
    clocks(10);
    chk("cfg", 128'(cfg), 128'(CONFIG_RESET));
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    chk("wake", 128'(wake_oe_n), 128'h0);
    chk("int", 128'(int_oe_n), 128'h1);
    $display("reset test done");
    xfer(24'h000000, exp_rsp(1'b0));
    ext_int_low <= 1'b1;
    xfer(24'h000000, exp_rsp(1'b0));
    ext_int_low <= 1'b0;
    $display("status test done");
    xfer(24'h01ab33, exp_rsp(1'b0));
    chk("polarity", 128'(cfg.polarity), 128'h33);
    pol = 8'h33;
    clocks(4);
    chk("int", 128'(int_oe_n), 128'h0);
    xfer(24'h000000, exp_rsp(1'b1));
    chk("int", 128'(int_oe_n), 128'h1);
    fork
      xfer(24'h000000, exp_rsp(1'b0));
      begin
        clocks(60);
        gnd[3] <= ~gnd[3];
      end
    join
    chk("int", 128'(int_oe_n), 128'h0);
    xfer(24'h000000, exp_rsp(1'b1));
    chk("int", 128'(int_oe_n), 128'h1);
    $display("interrupt test done");
    supply <= 1'b0;
    clocks(4);
    m.xfer(24, 48'h01ffff, rsp);
    chk("polarity", 128'(cfg.polarity), 128'h33);
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    nap();
    ext_int_low <= 1'b1;
    clocks(6);
    chk("mode", 128'(mode), 128'(MODE_SLEEP));
    ext_wake_low <= 1'b1;
    clocks(6);
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    ext_int_low <= 1'b0;
    ext_wake_low <= 1'b0;
    supply <= 1'b1;
    clocks(4);
    nap();
    ext_wake_low <= 1'b1;
    clocks(6);
    ext_wake_low <= 1'b0;
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    nap();
    ext_int_low <= 1'b1;
    clocks(6);
    ext_int_low <= 1'b0;
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    nap();
    m.xfer(24, 48'h000000, rsp);
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    nap();
    prog[0] <= ~prog[0];
    clocks(6);
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    chk("int", 128'(int_oe_n), 128'h0);
    xfer(24'h000000, exp_rsp(1'b1));
    nap();
    timer <= 1'b1;
    clocks(6);
    timer <= 1'b0;
    chk("mode", 128'(mode), 128'(MODE_NORMAL));
    $display("mode test done");
    thermal <= 1'b0;
    clocks(4);
    xfer(24'h030000, exp_rsp(1'b0));
    chk("wake_en", 128'(cfg.wake_en), 128'h0000ff);
    gnd[5] <= ~gnd[5];
    clocks(6);
    chk("int", 128'(int_oe_n), 128'h1);
    xfer(24'h0b0025, exp_rsp(1'b0));
    chk("analog", 128'({cfg.analog_cur, cfg.analog_sel}), 128'h25);
    xfer(24'h0200f0, exp_rsp(1'b0));
    xfer(24'h0400a5, exp_rsp(1'b0));
    xfer(24'h051234, exp_rsp(1'b0));
    xfer(24'h07005a, exp_rsp(1'b0));
    xfer(24'h082a2a, exp_rsp(1'b0));
    xfer(24'h0900c3, exp_rsp(1'b0));
    xfer(24'h0a3c3c, exp_rsp(1'b0));
    chk("settings", 128'({cfg.wake_en[7:0], cfg.wet_high, cfg.timer_en, cfg.tristate}),
      128'({8'hf0, 14'h1234, 8'ha5, 14'h2a2a, 8'h5a, 14'h3c3c, 8'hc3}));
    xfer(24'h0c0000, exp_rsp(1'b0));
    clocks(1);
    chk("calib", 128'(calib_seen), 128'h1);
    m.xfer(48, 48'h12345601ab0f, rsp);
    chk("chain", 128'(rsp), 128'({exp_rsp(1'b0), 24'h123456}));
    chk("polarity", 128'(cfg.polarity), 128'h0f);
    pol = 8'h0f;
    m.xfer(25, 48'h0155aa, rsp);
    chk("polarity", 128'(cfg.polarity), 128'h0f);
    xfer(24'h7f0000, exp_rsp(1'b0));
    chk("cfg", 128'(cfg), 128'(CONFIG_RESET));
    $display("command test done");
    give_verdict();
  end
endmodule
`default_nettype wire
